// [hdl/psi_pkg.sv]
// Package of register offsets, field positions and reset values
package psi_pkg;
	localparam logic [4:0]  ADDR_BSR     = 5'h01;
	localparam logic [4:0]  ADDR_STS     = 5'h10;
	localparam logic [4:0]  ADDR_ICR     = 5'h11;
	localparam logic [4:0]  ADDR_EVT     = 5'h12;
	localparam int          STS_LINK     = 0;
	localparam int          STS_SPD10    = 1;
	localparam int          STS_DUPLEX   = 2;
	localparam int          STS_LOOP     = 3;
	localparam int          STS_ANDONE   = 4;
	localparam int          STS_JAB      = 5;
	localparam int          STS_RFAULT   = 6;
	localparam int          STS_IRQ      = 7;
	localparam int          ICR_OE       = 0;
	localparam int          ICR_GEN      = 1;
	localparam int          ICR_TEST     = 2;
	localparam int          EVT_STAT_LSB = 8;
	localparam int          NUM_EVT      = 8;
	localparam logic [2:0]  ICR_RST      = 3'h0;
	localparam logic [7:0]  EVT_RST      = 8'h00;
endpackage

// [hdl/psi_evt_if.sv]
// Interface carrying event flags and enables to the event latch module
interface psi_evt_if;
	logic [7:0] evt;
	logic [7:0] en;
	logic       clr;
	logic [7:0] flags;
	logic       pend;
	modport top (output evt, output en, output clr, input flags, input pend);
	modport lat (input evt, input en, input clr, output flags, output pend);
endinterface

// [hdl/psi_evt_latch.sv]
// Sticky event flags with read-clear; set wins over clear
module psi_evt_latch (
	input  wire logic core_clk_i,   // Clock
	input  wire logic nrst_i,       // Async reset, active low
	psi_evt_if.lat    ev            // Event carrier
);
	typedef struct packed {
		logic [7:0] flags;
	} psi_lat_st_t;
	psi_lat_st_t s_q, s_d;

	always_comb
	begin
		s_d = s_q;
		if (ev.clr)
			s_d.flags = '0;
		s_d.flags = s_d.flags | ev.evt;   // [R16]
	end

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			s_q <= '{flags: psi_pkg::EVT_RST};
		else
			s_q <= s_d;
	end

	assign ev.flags = s_q.flags;
	assign ev.pend  = |(s_q.flags & ev.en);   // [R17]

	flag_sticks_a: assert property (   // [R16]
		@(posedge core_clk_i) disable iff (!nrst_i)
		(|ev.evt) |=> (s_q.flags & $past(ev.evt)) == $past(ev.evt))
		else $error("event flag not set");
endmodule

// [hdl/psi_top.sv]
// Status summary and interrupt control of one PHY port
// Summary of operation
// R1 - Remote fault bit 6 latches; cleared by basic status read or reset.
// R2 - Jabber in bit 5, meaningful only at 10 Mb/s.
// R3 - Summary jabber mirrors basic jabber; summary read does not clear.
// R4 - Bit 4 shows auto-negotiation complete.
// R5 - Bit 3 shows loopback enabled.
// R6 - Bit 2 shows resolved duplex, 1 full.
// R7 - Manager trusts duplex/speed only with link and negotiation settled.
// R8 - Bit 1 shows resolved speed, 1 means 10 Mb/s.
// R9 - Bit 0 shows valid link.
// R10 - Summary link mirrors basic link; summary read does not clear.
// R11 - Interrupt control at 11h, resets zero, bits 15:3 read zero.
// R12 - Test bit 2 forces interrupt while set.
// R13 - Bit 1 globally enables event interrupts.
// R14 - Bit 0 selects pin as interrupt output, else power-down input.
// R15 - Sources: energy, link, speed, duplex, negotiation, counter half-full.
// R16 - Event flags set even if disabled; event status read clears.
// R17 - Interrupt when enabled event occurs and control permits.
// R18 - Bit 7 shows pending interrupt; event status read clears it.
// R19 - Request is test OR (global AND enabled flag); pin driven in output mode.
module psi_top (
	input  wire logic        core_clk_i,   // Clock 125 MHz
	input  wire logic        nrst_i,       // Async reset, active low
	input  wire logic [4:0]  reg_addr_i,   // Management register address
	input  wire logic        reg_rd_i,     // Read strobe, one cycle
	input  wire logic        reg_wr_i,     // Write strobe, one cycle
	input  wire logic [15:0] reg_wdata_i,  // Write data
	output logic      [15:0] reg_rdata_o,  // Read data, registered
	input  wire logic        rfault_i,     // Remote fault pulse from AN
	input  wire logic        jabber_i,     // Latched basic-status jabber
	input  wire logic        an_done_i,    // Auto-negotiation complete
	input  wire logic        loopback_i,   // Loopback enabled
	input  wire logic        duplex_i,     // Resolved duplex, 1 full
	input  wire logic        speed10_i,    // Resolved speed, 1 is 10 Mb/s
	input  wire logic        link_i,       // Basic-status link bit
	input  wire logic [7:0]  evt_i,        // Event pulses, bit order as flags
	input  wire logic [7:0]  evt_en_i,     // Event enables from event reg
	output logic      [7:0]  evt_flags_o,  // Latched event flags
	input  wire logic        pin_i,        // Power-down/irq pin level in
	output logic             pin_o,        // Pin drive value, irq high
	output logic             pin_oe_o,     // Pin output enable
	output logic             pdown_o,      // Power-down request from pin
	output logic             irq_o         // Internal interrupt request
);
	typedef struct packed {
		logic        rfault;
		logic [2:0]  icr;
		logic [15:0] rdata;
		logic [1:0]  pin_s;
	} psi_st_t;
	psi_st_t s_q, s_d;

	psi_evt_if ev ();
	logic [15:0] sts;
	logic        rd_bsr;
	logic        rd_evt;
	logic        irq;

	assign rd_bsr = reg_rd_i && reg_addr_i == psi_pkg::ADDR_BSR;
	assign rd_evt = reg_rd_i && reg_addr_i == psi_pkg::ADDR_EVT;
	assign ev.evt = evt_i;   // [R15]
	assign ev.en  = evt_en_i;
	assign ev.clr = rd_evt;   // [R16]

	psi_evt_latch u_lat (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.ev         (ev)
	);

	// Request formed from test force or gated pending events
	assign irq = s_q.icr[psi_pkg::ICR_TEST] ||
		(s_q.icr[psi_pkg::ICR_GEN] && ev.pend);   // [R12] [R13] [R17] [R19]

	always_comb
	begin
		sts = 16'h0000;
		sts[psi_pkg::STS_LINK]   = link_i;       // [R9] [R10]
		sts[psi_pkg::STS_SPD10]  = speed10_i;    // [R8]
		sts[psi_pkg::STS_DUPLEX] = duplex_i;     // [R6]
		sts[psi_pkg::STS_LOOP]   = loopback_i;   // [R5]
		sts[psi_pkg::STS_ANDONE] = an_done_i;    // [R4]
		sts[psi_pkg::STS_JAB]    = jabber_i;     // [R2] [R3]
		sts[psi_pkg::STS_RFAULT] = s_q.rfault;   // [R1]
		sts[psi_pkg::STS_IRQ]    = ev.pend;      // [R18]
	end

	always_comb
	begin
		s_d = s_q;
		s_d.pin_s = {s_q.pin_s[0], pin_i};
		if (rd_bsr)
			s_d.rfault = 1'b0;
		if (rfault_i)
			s_d.rfault = 1'b1;   // [R1]
		if (reg_wr_i && reg_addr_i == psi_pkg::ADDR_ICR)
			s_d.icr = reg_wdata_i[2:0];   // [R11]
		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				psi_pkg::ADDR_STS: s_d.rdata = sts;
				psi_pkg::ADDR_ICR: s_d.rdata = {13'h0000, s_q.icr};   // [R11]
				psi_pkg::ADDR_EVT: s_d.rdata = {ev.flags, evt_en_i};
				default:           s_d.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			s_q <= '{rfault: 1'b0, icr: psi_pkg::ICR_RST,
				rdata: 16'h0000, pin_s: 2'h0};
		else
			s_q <= s_d;
	end

	assign reg_rdata_o = s_q.rdata;
	assign evt_flags_o = ev.flags;
	assign irq_o       = irq;
	assign pin_oe_o    = s_q.icr[psi_pkg::ICR_OE];   // [R14] [R19]
	assign pin_o       = irq & s_q.icr[psi_pkg::ICR_OE];   // [R14]
	assign pdown_o     = ~s_q.icr[psi_pkg::ICR_OE] & s_q.pin_s[1];   // [R14]

	sequence icr_write_s;
		reg_wr_i && reg_addr_i == psi_pkg::ADDR_ICR;
	endsequence

	sequence sts_read_s;
		reg_rd_i && reg_addr_i == psi_pkg::ADDR_STS;
	endsequence

	sequence evt_read_s;
		reg_rd_i && reg_addr_i == psi_pkg::ADDR_EVT;
	endsequence

	sequence bsr_read_s;
		reg_rd_i && reg_addr_i == psi_pkg::ADDR_BSR;
	endsequence

	// Remote fault: set by the partner, held until a basic status read
	rfault_latch_a: assert property (   // [R1]
		@(posedge core_clk_i) disable iff (!nrst_i)
		rfault_i |=> s_q.rfault)
		else $error("remote fault not latched");
	rfault_hold_a: assert property (   // [R1]
		@(posedge core_clk_i) disable iff (!nrst_i)
		(s_q.rfault && !rd_bsr) |=> s_q.rfault)
		else $error("remote fault lost without read");
	rfault_clear_a: assert property (   // [R1]
		@(posedge core_clk_i) disable iff (!nrst_i)
		(bsr_read_s ##0 !rfault_i) |=> !s_q.rfault)
		else $error("remote fault not cleared by read");
	rfault_read_a: assert property (   // [R1]
		@(posedge core_clk_i) disable iff (!nrst_i)
		sts_read_s |=> reg_rdata_o[6] == $past(s_q.rfault))
		else $error("remote fault bit misread");

	// Summary bits mirror their sources and reads leave them alone
	link_mirror_a: assert property (   // [R3] [R10]
		@(posedge core_clk_i) disable iff (!nrst_i)
		sts_read_s
		|=> reg_rdata_o[0] == $past(link_i)
		&& reg_rdata_o[5] == $past(jabber_i))
		else $error("link or jabber not mirrored");
	status_bits_a: assert property (   // [R4] [R5] [R6] [R8]
		@(posedge core_clk_i) disable iff (!nrst_i)
		sts_read_s
		|=> reg_rdata_o[4] == $past(an_done_i)
		&& reg_rdata_o[3] == $past(loopback_i)
		&& reg_rdata_o[2] == $past(duplex_i)
		&& reg_rdata_o[1] == $past(speed10_i))
		else $error("status bit not mirrored");
	irq_bit_a: assert property (   // [R18]
		@(posedge core_clk_i) disable iff (!nrst_i)
		sts_read_s |=> reg_rdata_o[7] == $past(ev.pend))
		else $error("pending bit misread");

	// Control register: three live bits, the rest read zero
	icr_write_a: assert property (   // [R11]
		@(posedge core_clk_i) disable iff (!nrst_i)
		icr_write_s |=> s_q.icr == 3'($past(reg_wdata_i)))
		else $error("control write not taken");
	icr_hold_a: assert property (   // [R11]
		@(posedge core_clk_i) disable iff (!nrst_i)
		!(reg_wr_i && reg_addr_i == psi_pkg::ADDR_ICR)
		|=> $stable(s_q.icr))
		else $error("control changed without write");
	icr_high_a: assert property (   // [R11]
		@(posedge core_clk_i) disable iff (!nrst_i)
		(reg_rd_i && reg_addr_i == psi_pkg::ADDR_ICR)
		|=> reg_rdata_o == {13'h0000, $past(s_q.icr)})
		else $error("reserved control bits nonzero");

	// Interrupt request and the shared pin
	test_force_a: assert property (   // [R12]
		@(posedge core_clk_i) disable iff (!nrst_i)
		(icr_write_s ##1 s_q.icr[psi_pkg::ICR_TEST]) |-> irq_o)
		else $error("test interrupt not forced");
	gen_off_a: assert property (   // [R13]
		@(posedge core_clk_i) disable iff (!nrst_i)
		(!s_q.icr[psi_pkg::ICR_GEN] && !s_q.icr[psi_pkg::ICR_TEST])
		|-> !irq_o)
		else $error("interrupt while disabled");
	evt_irq_a: assert property (   // [R17]
		@(posedge core_clk_i) disable iff (!nrst_i)
		(s_q.icr[psi_pkg::ICR_GEN] && |(evt_i & evt_en_i)) |=> irq_o)
		else $error("enabled event gave no interrupt");
	irq_source_a: assert property (   // [R17] [R19]
		@(posedge core_clk_i) disable iff (!nrst_i)
		(irq_o && !s_q.icr[psi_pkg::ICR_TEST])
		|-> (s_q.icr[psi_pkg::ICR_GEN] && |(ev.flags & evt_en_i)))
		else $error("interrupt without enabled source");
	pin_mode_a: assert property (   // [R14]
		@(posedge core_clk_i) disable iff (!nrst_i)
		!pin_oe_o |-> !pin_o)
		else $error("pin driven in input mode");
	pin_follow_a: assert property (   // [R14] [R19]
		@(posedge core_clk_i) disable iff (!nrst_i)
		pin_oe_o |-> (pin_o == irq_o && !pdown_o))
		else $error("output pin does not follow request");

	// Event flags
	evt_clear_a: assert property (   // [R18]
		@(posedge core_clk_i) disable iff (!nrst_i)
		(evt_read_s ##0 evt_i == 8'h00) |=> ev.flags == 8'h00 && !sts[7])
		else $error("event read did not clear");
	evt_read_data_a: assert property (   // [R16]
		@(posedge core_clk_i) disable iff (!nrst_i)
		evt_read_s |=> reg_rdata_o == {$past(ev.flags), $past(evt_en_i)})
		else $error("event register misread");
	evt_keep_a: assert property (   // [R16]
		@(posedge core_clk_i) disable iff (!nrst_i)
		!rd_evt |=> (ev.flags & $past(ev.flags)) == $past(ev.flags))
		else $error("event flag lost without read");
endmodule

// [tb/psi_mgmt.sv]
// Management controller model driving the register strobes
module psi_mgmt (
	output logic      [4:0]  addr_o,   // Register address
	output logic             rd_o,     // Read strobe
	output logic             wr_o,     // Write strobe
	output logic      [15:0] wdata_o,  // Write data
	input  wire logic        clk_i     // Clock
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		{addr_o, rd_o, wr_o, wdata_o} = '0;
	end
	// Idle bus shows inverted values so stale data is never mistaken
	task automatic access(input logic w, input logic [4:0] a,
		input logic [15:0] d);
		@(posedge clk_i);
		{rd_o, wr_o, addr_o, wdata_o} <= {~w, w, a, d};
		@(posedge clk_i);
		{rd_o, wr_o, addr_o, wdata_o} <= {2'b00, ~a, ~d};
	endtask
endmodule

// [tb/tb.sv]
// Self-checking bench of the status and interrupt control block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [4:0]  addr;
	logic        rd;
	logic        wr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [5:0]  lvl = 6'h00;
	logic [7:0]  evt = 8'h00;
	logic [7:0]  evt_en = 8'h00;
	logic [7:0]  flags;
	logic        rfault = 1'b0;
	logic        pin_ext = 1'b0;
	logic        pin_w;
	logic        pin_o;
	logic        pin_oe;
	logic        pdown;
	logic        irq;
	int          err_total = 0;
	int          total_checks = 0;
	logic [11:0] rows [4] = '{12'h000, 12'hfff, 12'h555, 12'haaa};
	assign pin_w = pin_oe ? pin_o : pin_ext;
	initial
	begin
		forever #4 clk = ~clk;
	end
	psi_mgmt mgmt_u (.clk_i(clk), .addr_o(addr), .rd_o(rd), .wr_o(wr),
		.wdata_o(wdata));
	psi_top dut_u (.core_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr),
		.reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata), .rfault_i(rfault), .jabber_i(lvl[5]),
		.an_done_i(lvl[4]), .loopback_i(lvl[3]), .duplex_i(lvl[2]),
		.speed10_i(lvl[1]), .link_i(lvl[0]), .evt_i(evt),
		.evt_en_i(evt_en), .evt_flags_o(flags), .pin_i(pin_w),
		.pin_o(pin_o), .pin_oe_o(pin_oe), .pdown_o(pdown), .irq_o(irq));
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdreg(input logic [4:0] a, input logic [15:0] e);
		mgmt_u.access(1'b0, a, 16'h0000);
		#1;
		chk("rdata", e, rdata);
	endtask
	task automatic pulse(input logic [7:0] v, input logic f);
		@(posedge clk);
		{evt, rfault} <= {v, f};
		@(posedge clk);
		{evt, rfault} <= 9'h000;
		#1;
	endtask
	task automatic report_and_stop();
		$display("Checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		#1;
		chk("pins", 16'h0000, {pin_oe, irq, flags});
		rdreg(psi_pkg::ADDR_ICR, 16'h0000);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			lvl <= rows[i][11:6];
			rdreg(psi_pkg::ADDR_STS, {10'h0, rows[i][5:0]});
			rdreg(psi_pkg::ADDR_STS, {10'h0, rows[i][5:0]});
		end
		mgmt_u.access(1'b1, psi_pkg::ADDR_ICR, 16'hffff);
		#1;
		chk("force", 16'h0007, {irq, pin_oe, pin_o});
		rdreg(psi_pkg::ADDR_ICR, 16'h0007);
		mgmt_u.access(1'b1, psi_pkg::ADDR_ICR, 16'h0002);
		pin_ext <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("pdown", 16'h0001, {irq, pin_oe, pdown});
		pulse(8'h04, 1'b0);
		chk("masked", 16'h0004, {irq, flags});
		@(posedge clk);
		evt_en <= 8'hff;
		#1;
		chk("enabled", 16'h0104, {irq, flags});
		rdreg(psi_pkg::ADDR_STS, 16'h00aa);
		rdreg(psi_pkg::ADDR_EVT, 16'h04ff);
		chk("cleared", 16'h0000, {irq, flags});
		mgmt_u.access(1'b1, psi_pkg::ADDR_ICR, 16'h0000);
		pulse(8'h10, 1'b0);
		chk("global", 16'h0010, {irq, flags});
		mgmt_u.access(1'b1, psi_pkg::ADDR_ICR, 16'h0002);
		rdreg(psi_pkg::ADDR_EVT, 16'h10ff);
		for (int i = 0; i < 8; i++)
		begin
			pulse(8'h01 << i, 1'b0);
			chk("source", {8'h01, 8'h01 << i}, {irq, flags});
			rdreg(psi_pkg::ADDR_EVT, {8'h01 << i, 8'hff});
		end
		pulse(8'h00, 1'b1);
		rdreg(psi_pkg::ADDR_STS, 16'h006a);
		rdreg(psi_pkg::ADDR_STS, 16'h006a);
		rdreg(psi_pkg::ADDR_BSR, 16'h0000);
		rdreg(psi_pkg::ADDR_STS, 16'h002a);
		fork
			mgmt_u.access(1'b0, psi_pkg::ADDR_EVT, 16'h0000);
			pulse(8'h20, 1'b0);
		join
		chk("clash rdata", 16'h00ff, rdata);
		chk("set wins", 16'h0120, {irq, flags});
		fork
			mgmt_u.access(1'b0, psi_pkg::ADDR_BSR, 16'h0000);
			pulse(8'h00, 1'b1);
		join
		rdreg(psi_pkg::ADDR_STS, 16'h00ea);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		#1;
		chk("reset rdata", 16'h0000, rdata);
		chk("reset pins", 16'h0000, {pin_oe, irq, flags});
		rdreg(psi_pkg::ADDR_STS, 16'h002a);
		rdreg(psi_pkg::ADDR_ICR, 16'h0000);
		report_and_stop();
	end
endmodule
